// ---- logic/pic_pkg.sv ----
// Shared constants and types for the pressure integration control block.
// Assumes one 20 MHz system clock and a plain address/strobe register port.
package pic_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Register port and offsets
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_PTIME = 8'h00;
    localparam logic [7:0] OFS_TTIME = 8'h04;
    localparam logic [7:0] OFS_PPER = 8'h08;
    localparam logic [7:0] OFS_TPER = 8'h0C;
    localparam logic [7:0] OFS_ORDER = 8'h10;
    localparam logic [7:0] OFS_ACQ = 8'h14;
    localparam logic [7:0] OFS_CMD = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_RESULT = 8'h20;
    localparam logic [7:0] OFS_MIN_VAL = 8'h24;
    localparam logic [7:0] OFS_MIN_STAMP = 8'h28;
    localparam logic [7:0] OFS_MAX_VAL = 8'h2C;
    localparam logic [7:0] OFS_MAX_STAMP = 8'h30;

    ////////////////////////////////////////////////////////////////////////
    // Field widths, limits and reset values
    localparam int MS_W = 19;
    localparam int PPER_W = 14;
    localparam int TPER_W = 16;
    localparam logic [18:0] TIME_MAX = 19'h46CD0;
    localparam logic [18:0] TIME_RST = 19'h0029A;
    localparam logic [15:0] PPER_MAX = 16'h3FFF;
    localparam logic [13:0] PPER_RST = 14'h00EE;
    localparam logic [15:0] TPER_MAX = 16'hFFFF;
    localparam logic [15:0] TPER_RST = 16'h03B8;
    localparam int TPER_SCALE_SHIFT = 2;

    // Command and status bits
    localparam int CMD_MEAS_BIT = 0;
    localparam int CMD_EXTRST_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_MODE_BIT = 1;
    localparam int ST_RESVAL_BIT = 2;
    localparam int ST_EXTVAL_BIT = 3;
    localparam int ST_REQ_BIT = 4;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic {PIC_TIME_BASED, PIC_PERIOD_BASED} pic_int_mode_t;
    typedef enum logic {PIC_SIMULTANEOUS, PIC_SEQUENTIAL} pic_order_t;
    typedef enum logic {PIC_TRIGGER, PIC_FETCH} pic_acq_t;

    localparam pic_order_t ORDER_RST = PIC_SEQUENTIAL;
    localparam pic_acq_t ACQ_RST = PIC_TRIGGER;
    localparam pic_int_mode_t MODE_RST = PIC_TIME_BASED;

    typedef struct packed {
        logic [MS_W-1:0] ptime;
        logic [MS_W-1:0] ttime;
        logic [PPER_W-1:0] pper;
        logic [TPER_W-1:0] tper;
        pic_int_mode_t mode;
        pic_order_t order;
        pic_acq_t acq;
    } pic_settings_t;

    typedef struct packed {
        logic [31:0] value;
        logic [31:0] stamp;
    } pic_extreme_t;

endpackage : pic_pkg

// ---- logic/pic_integrator.sv ----
// One integration channel: counts clock cycles over a window.
// Assumes a one-cycle ms tick and a synchronised rising-edge pulse.
`timescale 1ns/1ns
module pic_integrator (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire pic_pkg::pic_int_mode_t i_mode,
    input wire logic [18:0] i_ms_limit,
    input wire logic [15:0] i_per_limit,
    input wire logic i_ms_tick,
    input wire logic i_edge,
    output logic o_done,
    output logic [31:0] o_cycles
);

    logic busy;
    logic armed;
    logic [18:0] units;
    logic [31:0] cycles;
    logic step;
    logic [18:0] limit;

    ////////////////////////////////////////////////////////////////////////
    // Window unit: ms ticks or signal periods
    always_comb begin
        if (i_mode == pic_pkg::PIC_TIME_BASED) begin
            step = i_ms_tick;
            limit = i_ms_limit;
        end else begin
            step = i_edge;
            limit = {3'h0, i_per_limit};
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy <= 1'b0;
            armed <= 1'b0;
            units <= 19'h00000;
            cycles <= 32'h00000000;
            o_done <= 1'b0;
            o_cycles <= 32'h00000000;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                busy <= 1'b1;
                armed <= (i_mode == pic_pkg::PIC_TIME_BASED);
                units <= 19'h00000;
                cycles <= 32'h00000000;
            end else if (busy && !armed) begin
                armed <= i_edge;
            end else if (busy) begin
                cycles <= cycles + 32'h00000001;
                if (step) begin
                    units <= units + 19'h00001;
                    if (units + 19'h00001 >= limit) begin
                        busy <= 1'b0;
                        o_done <= 1'b1;
                        o_cycles <= cycles + 32'h00000001;
                    end
                end
            end
        end
    end

endmodule : pic_integrator

// ---- logic/pic_control.sv ----
// Pressure integration control: settings, measurement sequencing,
// trigger/fetch replies and min/max tracking with time stamps.
// Assumes transducer signals from pins and request pulses, time stamp
// and parameter-change pulses from logic on the same clock.
`timescale 1ns/1ns
module pic_control #(
    parameter int P_CYCLES_PER_MS = pic_pkg::CYCLES_PER_MS
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_press_sig,
    input wire logic i_temp_sig,
    input wire logic [1:0] i_meas_req,
    input wire logic i_param_change,
    input wire logic [31:0] i_timestamp,
    output logic [1:0] o_reply_valid,
    output logic [31:0] o_reply_value,
    output logic o_ext_ack
);

    typedef enum {SEQ_IDLE, SEQ_TEMP, SEQ_PRES, SEQ_BOTH, SEQ_FINISH} pic_seq_t;

    pic_pkg::pic_settings_t cfg;
    pic_pkg::pic_extreme_t ext_min;
    pic_pkg::pic_extreme_t ext_max;
    pic_seq_t seq;
    logic [31:0] tick_cnt;
    logic ms_tick;
    logic [2:0] press_sync;
    logic [2:0] temp_sync;
    logic press_edge;
    logic temp_edge;
    logic p_start;
    logic t_start;
    logic p_done;
    logic t_done;
    logic [31:0] p_cycles;
    logic p_seen;
    logic t_seen;
    logic meas_done;
    logic [31:0] result;
    logic res_valid;
    logic [2:0] wait_req;
    logic [2:0] inflight;
    logic reinit;
    logic ext_valid;
    logic wr_cmd_meas;
    logic wr_cmd_ext;
    logic fetch;
    logic sequential;

    ////////////////////////////////////////////////////////////////////////
    // Accept only values 1..max
    function automatic logic in_range(input logic [31:0] val, input logic [15:0] hi_unused,
                                      input logic [18:0] max);
        in_range = (val != 32'h00000000) && (val <= {13'h0000, max}) && (hi_unused == 16'h0000);
    endfunction : in_range

    // Register read mux
    function automatic logic [31:0] read_word(input logic [7:0] addr);
        case (addr)
            pic_pkg::OFS_PTIME: read_word = {13'h0000, cfg.ptime};
            pic_pkg::OFS_TTIME: read_word = {13'h0000, cfg.ttime};
            pic_pkg::OFS_PPER: read_word = {18'h00000, cfg.pper};
            pic_pkg::OFS_TPER: read_word = {16'h0000, cfg.tper};
            pic_pkg::OFS_ORDER: read_word = {31'h00000000, cfg.order};
            pic_pkg::OFS_ACQ: read_word = {31'h00000000, cfg.acq};
            pic_pkg::OFS_STATUS: read_word = {27'h0000000, (wait_req != 3'h0), ext_valid,
                                              res_valid, cfg.mode, (seq != SEQ_IDLE)};
            pic_pkg::OFS_RESULT: read_word = result;
            pic_pkg::OFS_MIN_VAL: read_word = ext_min.value;
            pic_pkg::OFS_MIN_STAMP: read_word = ext_min.stamp;
            pic_pkg::OFS_MAX_VAL: read_word = ext_max.value;
            pic_pkg::OFS_MAX_STAMP: read_word = ext_max.stamp;
            default: read_word = 32'h00000000;
        endcase
    endfunction : read_word

    assign fetch = (cfg.acq == pic_pkg::PIC_FETCH);
    assign sequential = (cfg.order == pic_pkg::PIC_SEQUENTIAL);
    assign wr_cmd_meas = i_wr && (i_addr == pic_pkg::OFS_CMD) && i_wdata[pic_pkg::CMD_MEAS_BIT];
    assign wr_cmd_ext = i_wr && (i_addr == pic_pkg::OFS_CMD) && i_wdata[pic_pkg::CMD_EXTRST_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= read_word(i_addr);
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Integration settings
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg.ptime <= pic_pkg::TIME_RST;
            cfg.ttime <= pic_pkg::TIME_RST;
            cfg.pper <= pic_pkg::PPER_RST;
            cfg.tper <= pic_pkg::TPER_RST;
            cfg.mode <= pic_pkg::MODE_RST;
            cfg.order <= pic_pkg::ORDER_RST;
            cfg.acq <= pic_pkg::ACQ_RST;
        end else if (i_wr) begin
            case (i_addr)
                pic_pkg::OFS_PTIME: begin
                    if (in_range(i_wdata, 16'h0000, pic_pkg::TIME_MAX)) begin
                        cfg.ptime <= i_wdata[pic_pkg::MS_W-1:0];
                        cfg.ttime <= i_wdata[pic_pkg::MS_W-1:0];
                        cfg.mode <= pic_pkg::PIC_TIME_BASED;
                    end
                end
                pic_pkg::OFS_TTIME: begin
                    if (in_range(i_wdata, 16'h0000, pic_pkg::TIME_MAX)) begin
                        cfg.ttime <= i_wdata[pic_pkg::MS_W-1:0];
                        cfg.mode <= pic_pkg::PIC_TIME_BASED;
                    end
                end
                pic_pkg::OFS_PPER: begin
                    if (in_range(i_wdata, 16'h0000, {3'h0, pic_pkg::PPER_MAX})) begin
                        cfg.pper <= i_wdata[pic_pkg::PPER_W-1:0];
                        cfg.tper <= {i_wdata[pic_pkg::PPER_W-1:0],
                                     2'h0} << (pic_pkg::TPER_SCALE_SHIFT - 2);
                        cfg.mode <= pic_pkg::PIC_PERIOD_BASED;
                    end
                end
                pic_pkg::OFS_TPER: begin
                    if (in_range(i_wdata, 16'h0000, {3'h0, pic_pkg::TPER_MAX})) begin
                        cfg.tper <= i_wdata[pic_pkg::TPER_W-1:0];
                        cfg.mode <= pic_pkg::PIC_PERIOD_BASED;
                    end
                end
                pic_pkg::OFS_ORDER: begin
                    cfg.order <= pic_pkg::pic_order_t'(i_wdata[0]);
                end
                pic_pkg::OFS_ACQ: begin
                    cfg.acq <= pic_pkg::pic_acq_t'(i_wdata[0]);
                end
                default: begin
                    cfg.mode <= cfg.mode;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tick_cnt <= 32'h00000000;
            ms_tick <= 1'b0;
        end else if (tick_cnt == 32'(P_CYCLES_PER_MS - 1)) begin
            tick_cnt <= 32'h00000000;
            ms_tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
            ms_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transducer pin synchronisers and edge detect
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            press_sync <= 3'h0;
            temp_sync <= 3'h0;
        end else begin
            press_sync <= {press_sync[1:0], i_press_sig};
            temp_sync <= {temp_sync[1:0], i_temp_sig};
        end
    end

    assign press_edge = press_sync[1] && !press_sync[2];
    assign temp_edge = temp_sync[1] && !temp_sync[2];

    ////////////////////////////////////////////////////////////////////////
    // Integration channels
    pic_integrator u_press (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_start(p_start),
        .i_mode(cfg.mode),
        .i_ms_limit(cfg.ptime),
        .i_per_limit({2'h0, cfg.pper}),
        .i_ms_tick(ms_tick),
        .i_edge(press_edge),
        .o_done(p_done),
        .o_cycles(p_cycles)
    );

    pic_integrator u_temp (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_start(t_start),
        .i_mode(cfg.mode),
        .i_ms_limit(cfg.ttime),
        .i_per_limit(cfg.tper),
        .i_ms_tick(ms_tick),
        .i_edge(temp_edge),
        .o_done(t_done),
        .o_cycles()
    );

    ////////////////////////////////////////////////////////////////////////
    // Measurement sequencer
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            seq <= SEQ_IDLE;
            p_start <= 1'b0;
            t_start <= 1'b0;
            p_seen <= 1'b0;
            t_seen <= 1'b0;
            meas_done <= 1'b0;
        end else begin
            p_start <= 1'b0;
            t_start <= 1'b0;
            meas_done <= 1'b0;
            case (seq)
                SEQ_IDLE: begin
                    if (fetch || (wait_req != 3'h0)) begin
                        p_seen <= 1'b0;
                        t_seen <= 1'b0;
                        t_start <= 1'b1;
                        if (sequential) begin
                            seq <= SEQ_TEMP;
                        end else begin
                            p_start <= 1'b1;
                            seq <= SEQ_BOTH;
                        end
                    end
                end
                SEQ_TEMP: begin
                    if (t_done) begin
                        p_start <= 1'b1;
                        seq <= SEQ_PRES;
                    end
                end
                SEQ_PRES: begin
                    if (p_done) begin
                        seq <= SEQ_FINISH;
                    end
                end
                SEQ_BOTH: begin
                    p_seen <= p_seen || p_done;
                    t_seen <= t_seen || t_done;
                    if ((p_seen || p_done) && (t_seen || t_done)) begin
                        seq <= SEQ_FINISH;
                    end
                end
                SEQ_FINISH: begin
                    meas_done <= 1'b1;
                    seq <= SEQ_IDLE;
                end
                default: begin
                    seq <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Ordering only steers this sequencer of the temperature and pressure channels.

    ////////////////////////////////////////////////////////////////////////
    // Latest result
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            result <= 32'h00000000;
            res_valid <= 1'b0;
        end else if (p_done) begin
            result <= p_cycles;
            res_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request tracking and replies
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_req <= 3'h0;
            inflight <= 3'h0;
            o_reply_valid <= 2'h0;
            o_reply_value <= 32'h00000000;
        end else if (fetch) begin
            o_reply_valid <= (wait_req[1:0] | i_meas_req) & {2{res_valid}};
            o_reply_value <= result;
            wait_req <= (wait_req | {wr_cmd_meas, i_meas_req}) & {3{!res_valid}};
            inflight <= 3'h0;
        end else begin
            o_reply_valid <= 2'h0;
            if (meas_done) begin
                o_reply_valid <= inflight[1:0];
                o_reply_value <= result;
                inflight <= 3'h0;
            end
            if ((seq == SEQ_IDLE) && (wait_req != 3'h0)) begin
                inflight <= wait_req;
                wait_req <= {wr_cmd_meas, i_meas_req};
            end else begin
                wait_req <= wait_req | {wr_cmd_meas, i_meas_req};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Extremes with time stamps
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            reinit <= 1'b1;
            ext_valid <= 1'b0;
            ext_min <= '0;
            ext_max <= '0;
            o_ext_ack <= 1'b0;
        end else begin
            o_ext_ack <= wr_cmd_ext;
            if (p_done) begin
                if (reinit) begin
                    ext_min <= '{value: p_cycles, stamp: i_timestamp};
                    ext_max <= '{value: p_cycles, stamp: i_timestamp};
                    ext_valid <= 1'b1;
                end else begin
                    if (p_cycles < ext_min.value) begin
                        ext_min <= '{value: p_cycles, stamp: i_timestamp};
                    end
                    if (p_cycles > ext_max.value) begin
                        ext_max <= '{value: p_cycles, stamp: i_timestamp};
                    end
                end
            end
            if (wr_cmd_ext || i_param_change) begin
                reinit <= 1'b1;
            end else if (p_done) begin
                reinit <= 1'b0;
            end
        end
    end

endmodule : pic_control

// ---- verification/pic_control_properties.sv ----
// Checker for pic_control register port and extremes acknowledge.
// Assumes a bind to pic_control and its single clock domain.
`timescale 1ns/1ns
module pic_control_properties (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_ext_ack
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // Accepted write, then read
    sequence s_wr_rd(logic [7:0] w, logic [7:0] r, logic [31:0] m);
        i_wr && i_addr == w && i_wdata != 32'h0 && i_wdata <= m ##1 i_rd && i_addr == r;
    endsequence
    sequence s_bit_rd(logic [7:0] a);
        i_wr && i_addr == a && i_wdata[31:1] == 31'h0 ##1 i_rd && i_addr == a;
    endsequence
    property p_rdata_idle;
        !i_rd |=> o_rdata == 32'h0;
    endproperty
    property p_ptime_rw;
        s_wr_rd(8'h00, 8'h00, 32'h46CD0) |=> o_rdata == $past(i_wdata, 2);
    endproperty
    property p_ptime_copy;
        s_wr_rd(8'h00, 8'h04, 32'h46CD0) |=> o_rdata == $past(i_wdata, 2);
    endproperty
    property p_pper_scale;
        s_wr_rd(8'h08, 8'h0C, 32'h3FFF) |=> o_rdata == ($past(i_wdata, 2) << 2);
    endproperty
    property p_mode_period;
        s_wr_rd(8'h08, 8'h1C, 32'h3FFF) |=> o_rdata[1];
    endproperty
    property p_mode_time;
        s_wr_rd(8'h00, 8'h1C, 32'h46CD0) |=> !o_rdata[1];
    endproperty
    property p_order_rw;
        s_bit_rd(8'h10) |=> o_rdata == $past(i_wdata, 2);
    endproperty
    property p_acq_rw;
        s_bit_rd(8'h14) |=> o_rdata == $past(i_wdata, 2);
    endproperty
    property p_ext_ack;
        i_wr && i_addr == 8'h18 && i_wdata[1] |=> o_ext_ack;
    endproperty
    property p_unmapped;
        i_rd && i_addr == 8'h40 |=> o_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_ptime_rw: assert property (p_ptime_rw) else $error("ptime readback");
    a_ptime_copy: assert property (p_ptime_copy) else $error("ttime copy");
    a_pper_scale: assert property (p_pper_scale) else $error("tper scale");
    a_mode_period: assert property (p_mode_period) else $error("period mode");
    a_mode_time: assert property (p_mode_time) else $error("time mode");
    a_order_rw: assert property (p_order_rw) else $error("order readback");
    a_acq_rw: assert property (p_acq_rw) else $error("acq readback");
    a_ext_ack: assert property (p_ext_ack) else $error("no ext ack");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : pic_control_properties
bind pic_control pic_control_properties u_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_ext_ack(o_ext_ack));

// ---- verification/pic_host.sv ----
// Serial host model issuing measurement requests on two ports.
// Assumes the reply strobes of pic_control on the same clock.
`timescale 1ns/1ns
module pic_host (
    input wire logic i_clk_sys,
    input wire logic [1:0] i_reply_valid,
    output logic [1:0] o_meas_req
);
    initial o_meas_req = 2'h0;
    // Request, bounded wait, resend once if unanswered
    task automatic request(input logic [1:0] m, output logic ok);
        ok = 1'b0;
        for (int t = 0; t < 2 && !ok; t++) begin
            @(posedge i_clk_sys);
            o_meas_req <= m;
            @(posedge i_clk_sys);
            o_meas_req <= 2'h0;
            for (int n = 0; n < 400 && !ok; n++) begin
                #1 ok = (i_reply_valid === m);
                if (!ok) @(posedge i_clk_sys);
            end
        end
    endtask : request
endmodule : pic_host

// ---- verification/pic_control_test.sv ----
// Self-checking bench for pic_control.
// Assumes the host model and a bound checker.
`timescale 1ns/1ns
module pic_control_test;
    typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} pic_row_t;
    logic i_clk_sys, i_sys_rst, i_wr, i_rd, i_press_sig, i_temp_sig, i_param_change, o_ext_ack, ok;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, i_timestamp, o_reply_value, rv, v1;
    logic [1:0] meas_req, o_reply_valid;
    logic [3:0] ph;
    int n_mismatch, cmp_count;
    pic_row_t rows [10] = '{
        '{8'h08, 32'hC8, 8'h0C, 32'h320},
        '{8'h08, 32'h3FFF, 8'h0C, 32'hFFFC},
        '{8'h0C, 32'h5, 8'h08, 32'h3FFF},
        '{8'h08, 32'h4000, 8'h08, 32'h3FFF},
        '{8'h00, 32'h46CD0, 8'h04, 32'h46CD0},
        '{8'h04, 32'h7, 8'h00, 32'h46CD0},
        '{8'h00, 32'h0, 8'h00, 32'h46CD0},
        '{8'h04, 32'h46CD1, 8'h04, 32'h7},
        '{8'h10, 32'h0, 8'h10, 32'h0},
        '{8'h40, 32'h5A, 8'h40, 32'h0}};
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    // Transducer square waves
    always @(posedge i_clk_sys) begin
        ph <= ph + 4'h1;
        i_press_sig <= ph[1];
        i_temp_sig <= ph[2];
    end
    pic_control #(.P_CYCLES_PER_MS(4)) dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_press_sig(i_press_sig), .i_temp_sig(i_temp_sig), .i_meas_req(meas_req),
        .i_param_change(i_param_change), .i_timestamp(i_timestamp),
        .o_reply_valid(o_reply_valid), .o_reply_value(o_reply_value), .o_ext_ack(o_ext_ack));
    pic_host host (.i_clk_sys(i_clk_sys), .i_reply_valid(o_reply_valid), .o_meas_req(meas_req));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        rd(a, rv);
        chk(nm, ex, rv);
    endtask : rchk
    task automatic meas(input logic [31:0] ts, input logic [1:0] m);
        i_timestamp <= ts;
        host.request(m, ok);
        chk("reply", 32'h1, {31'h0, ok});
    endtask : meas
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        {i_sys_rst, i_wr, i_rd, i_param_change, ph, i_press_sig, i_temp_sig} = 10'h200;
        {i_addr, i_wdata, i_timestamp} = 72'h0;
        repeat (6) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        rchk("ptime", 8'h00, 32'h29A);
        rchk("ttime", 8'h04, 32'h29A);
        rchk("pper", 8'h08, 32'hEE);
        rchk("tper", 8'h0C, 32'h3B8);
        rchk("order", 8'h10, 32'h1);
        rchk("acq", 8'h14, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rchk("row", rows[i].ra, rows[i].ex);
        end
        wr(8'h00, 32'h2);
        rd(8'h1C, rv);
        chk("mode", 32'h0, {31'h0, rv[1]});
        wr(8'h08, 32'h64);
        rd(8'h1C, rv);
        chk("mode", 32'h1, {31'h0, rv[1]});
        wr(8'h10, 32'h1);
        rd(8'h1C, rv);
        chk("mode", 32'h1, {31'h0, rv[1]});
        wr(8'h04, 32'h2);
        rd(8'h1C, rv);
        chk("mode", 32'h0, {31'h0, rv[1]});
        meas(32'h11, 2'h1);
        v1 = o_reply_value;
        wr(8'h00, 32'h3);
        rchk("ptime", 8'h00, 32'h3);
        meas(32'h22, 2'h2);
        rchk("min", 8'h24, v1);
        rchk("min stamp", 8'h28, 32'h11);
        rchk("max stamp", 8'h30, 32'h22);
        rd(8'h2C, rv);
        chk("max above", 32'h1, {31'h0, rv > v1});
        wr(8'h18, 32'h2);
        rd(8'h1C, rv);
        meas(32'h33, 2'h1);
        rchk("max stamp", 8'h30, 32'h33);
        rchk("min stamp", 8'h28, 32'h33);
        @(posedge i_clk_sys);
        i_param_change <= 1'b1;
        @(posedge i_clk_sys);
        i_param_change <= 1'b0;
        wr(8'h00, 32'h4);
        rd(8'h00, rv);
        meas(32'h44, 2'h1);
        rchk("min stamp", 8'h28, 32'h44);
        wr(8'h10, 32'h0);
        wr(8'h08, 32'h2);
        rchk("tper", 8'h0C, 32'h8);
        meas(32'h66, 2'h1);
        chk("period value", 32'h8, o_reply_value);
        rchk("min", 8'h24, 32'h8);
        rchk("min stamp", 8'h28, 32'h66);
        wr(8'h14, 32'h1);
        rchk("acq", 8'h14, 32'h1);
        meas(32'h55, 2'h3);
        chk("fetch value", 32'h8, o_reply_value);
        end_of_test();
    end
endmodule : pic_control_test
